// [rtl/rss_top.sv]
// Reset source sequencer with cause status, break control and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "rss_defs.svh"

module rss_top #(
	parameter int unsigned OSC_DIV     = `RSS_OSC_DIV,                      // System clocks per oscillator cycle
	parameter int unsigned PIN_CYCLES  = `RSS_PIN_CYCLES,                   // Pin drive time, oscillator cycles
	parameter int unsigned LOWV_CYCLES = `RSS_LOWV_EXTRA + `RSS_PIN_CYCLES  // Low-voltage pin drive time
) (
	input  wire logic              clk,                // System clock, 200 MHz
	input  wire logic              rst,                // Power-on reset, synchronous, high
	// AXI4-Lite slave
	input  wire logic [7:0]        s_axi_awaddr,       // Write address
	input  wire logic              s_axi_awvalid,      // Write address valid
	output logic                   s_axi_awready,      // Write address ready
	input  wire logic [31:0]       s_axi_wdata,        // Write data
	input  wire logic [3:0]        s_axi_wstrb,        // Write byte strobes
	input  wire logic              s_axi_wvalid,       // Write data valid
	output logic                   s_axi_wready,       // Write data ready
	output logic [1:0]             s_axi_bresp,        // Write response
	output logic                   s_axi_bvalid,       // Write response valid
	input  wire logic              s_axi_bready,       // Write response ready
	input  wire logic [7:0]        s_axi_araddr,       // Read address
	input  wire logic              s_axi_arvalid,      // Read address valid
	output logic                   s_axi_arready,      // Read address ready
	output logic [31:0]            s_axi_rdata,        // Read data
	output logic [1:0]             s_axi_rresp,        // Read response
	output logic                   s_axi_rvalid,       // Read data valid
	input  wire logic              s_axi_rready,       // Read data ready
	// Reset causes from the rest of the chip
	input  wire logic              watchdog_overflow,  // Watchdog counter overflow pulse
	input  wire logic              illegal_opcode,     // CPU decode found illegal instruction
	input  wire logic              stop_exec,          // CPU executes the stop instruction
	input  wire logic              unmapped_access,    // CPU access hits an unmapped address
	input  wire logic              opcode_fetch,       // Current access is an opcode fetch
	input  wire logic              low_voltage_trip,   // Supply fell to the trip level
	input  wire logic              monitor_entry,      // Monitor entered with blank vector, irq at supply
	// Mode and test-voltage detects
	input  wire logic              monitor_mode,       // Device is in monitor mode
	input  wire logic              break_state,        // Debug break interrupt active
	input  wire logic              rst_pin_hv,         // Test high voltage on reset pin
	input  wire logic              irq_pin_hv,         // Test high voltage on interrupt pin
	// Open-drain reset pin
	input  wire logic              rst_pin_i,          // Reset pin level, low is reset
	output logic                   rst_pin_o,          // Reset pin drive value, always low
	output logic                   rst_pin_oe_n,       // Drive enable, low while pulling pin down
	// Results
	output logic                   chip_reset,         // Internal chip reset, high while held
	output logic                   watchdog_disable,   // Watchdog disabled, combinational
	output rss_pkg::rss_flags_t    last_cause,         // Current cause flags
	output logic                   irq                 // Level interrupt
);
	import rss_pkg::*;

	// ------------------------------------------------------------------------
	// Local widths and counts
	// ------------------------------------------------------------------------
	localparam int unsigned CW = $clog2(LOWV_CYCLES + 1) > 6 ? $clog2(LOWV_CYCLES + 1) : 6; // Counter width
	localparam logic [CW-1:0] PIN_LAST  = CW'(PIN_CYCLES - 1);        // Last count, normal drive
	localparam logic [CW-1:0] LOWV_LAST = CW'(LOWV_CYCLES - 1);       // Last count, low-voltage drive
	localparam logic [CW-1:0] HOLD_LAST = CW'(`RSS_HOLD_CYCLES - 1);  // Last count, internal hold
	localparam int unsigned DW = $clog2(OSC_DIV + 1);                 // Divider width
	localparam logic [DW-1:0] DIV_LAST  = DW'(OSC_DIV - 1);           // Divider wrap value

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	rss_state_e    state_q, state_d;          // Sequencer state
	logic [CW-1:0] cnt_q, cnt_d;              // Oscillator cycle counter
	logic [DW-1:0] div_q, div_d;              // Oscillator enable divider
	rss_flags_t    cause_q, cause_d;          // Reset cause flags
	logic [7:0]    brk_q, brk_d;              // Break auxiliary control
	logic [7:0]    opt_q, opt_d;              // Option control
	rss_flags_t    ist_q, ist_d;              // Interrupt status, sticky
	rss_flags_t    ien_q, ien_d;              // Interrupt enable
	logic          aw_got_q, aw_got_d;        // Write address held
	logic [7:0]    awaddr_q, awaddr_d;        // Held write address
	logic          w_got_q, w_got_d;          // Write data held
	logic [31:0]   wdata_q, wdata_d;          // Held write data
	logic          wstrb0_q, wstrb0_d;        // Held low byte strobe
	logic          bvalid_q, bvalid_d;        // Write response pending
	logic [1:0]    bresp_q, bresp_d;          // Write response code
	logic          rvalid_q, rvalid_d;        // Read data pending
	logic [31:0]   rdata_q, rdata_d;          // Read data
	logic [1:0]    rresp_q, rresp_d;          // Read response code

	// Combinational helpers
	logic          osc_tick;                  // One pulse per oscillator cycle
	logic          wd_ev;                     // Qualified watchdog event
	logic          badop_ev;                  // Illegal instruction event
	logic          badad_ev;                  // Illegal address event
	logic          lowv_ev;                   // Low-voltage event
	logic          mode_ev;                   // Monitor entry event
	logic          pin_ev;                    // External pin event
	logic          int_ev;                    // Any internal source
	rss_flags_t    ev_set;                    // Flags raised this cycle
	logic          wr_go;                     // Register write happens
	logic          rd_go;                     // Register read happens

	// ------------------------------------------------------------------------
	// Watchdog disable, pure gates on the mode, break and high-voltage detects and the break disable bit
	// ------------------------------------------------------------------------
	always_comb begin
		watchdog_disable = (monitor_mode & (rst_pin_hv | irq_pin_hv))
			| (break_state & rst_pin_hv)
			| (break_state & brk_q[`RSS_BIT_BRKDIS]);
	end

	// ------------------------------------------------------------------------
	// Event qualification, taken only while the chip runs
	// ------------------------------------------------------------------------
	always_comb begin
		wd_ev    = state_q == RSS_IDLE && watchdog_overflow && !watchdog_disable;
		badop_ev = state_q == RSS_IDLE
			&& (illegal_opcode || (stop_exec && !opt_q[`RSS_BIT_STOPEN]));
		badad_ev = state_q == RSS_IDLE && unmapped_access && opcode_fetch;
		lowv_ev  = state_q == RSS_IDLE && low_voltage_trip;
		mode_ev  = state_q == RSS_IDLE && monitor_entry;
		int_ev   = wd_ev | badop_ev | badad_ev | lowv_ev | mode_ev;
		pin_ev   = state_q == RSS_IDLE && !int_ev && !rst_pin_i;
		ev_set   = '0;
		ev_set[`RSS_BIT_PIN]   = pin_ev;
		ev_set[`RSS_BIT_WDOG]  = wd_ev;
		ev_set[`RSS_BIT_BADOP] = badop_ev;
		ev_set[`RSS_BIT_BADAD] = badad_ev;
		ev_set[`RSS_BIT_MODE]  = mode_ev;
		ev_set[`RSS_BIT_LOWV]  = lowv_ev;
	end

	// ------------------------------------------------------------------------
	// Oscillator enable divider
	// ------------------------------------------------------------------------
	always_comb begin
		osc_tick = div_q == DIV_LAST;
		div_d    = osc_tick ? '0 : div_q + DW'(1);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	// ------------------------------------------------------------------------
	// Reset sequencer
	// ------------------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			RSS_IDLE: begin
				// Internal source: pull the pin down
				if (int_ev) begin
					state_d = RSS_DRIVE;
					cnt_d   = lowv_ev ? LOWV_LAST : PIN_LAST;
				end else if (pin_ev) begin
					state_d = RSS_EXT;
				end
			end
			RSS_DRIVE: begin
				// Count pin-low oscillator cycles
				if (osc_tick) begin
					if (cnt_q == '0) begin
						state_d = RSS_HOLD;
						cnt_d   = HOLD_LAST;
					end else begin
						cnt_d = cnt_q - CW'(1);
					end
				end
			end
			RSS_HOLD: begin
				// Pin released, chip still held
				if (osc_tick) begin
					if (cnt_q == '0) begin
						state_d = RSS_IDLE;
					end else begin
						cnt_d = cnt_q - CW'(1);
					end
				end
			end
			RSS_EXT: begin
				// Held until the outside lets the pin go
				if (rst_pin_i) begin
					state_d = RSS_HOLD;
					cnt_d   = HOLD_LAST;
				end
			end
			default: begin
				state_d = RSS_IDLE;
				cnt_d   = '0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= RSS_IDLE;
			cnt_q   <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// ------------------------------------------------------------------------
	// AXI4-Lite handshakes
	// ------------------------------------------------------------------------
	always_comb begin
		s_axi_awready = !aw_got_q && !bvalid_q;
		s_axi_wready  = !w_got_q && !bvalid_q;
		s_axi_arready = !rvalid_q;
		wr_go         = aw_got_q && w_got_q && !bvalid_q;
		rd_go         = s_axi_arvalid && s_axi_arready;
	end

	// ------------------------------------------------------------------------
	// Register file and bus next values
	// ------------------------------------------------------------------------
	always_comb begin
		aw_got_d = aw_got_q;
		awaddr_d = awaddr_q;
		w_got_d  = w_got_q;
		wdata_d  = wdata_q;
		wstrb0_d = wstrb0_q;
		bvalid_d = bvalid_q;
		bresp_d  = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		brk_d    = brk_q;
		opt_d    = opt_q;
		ien_d    = ien_q;
		cause_d  = cause_q;
		ist_d    = ist_q;
		// Capture write address and data in either order
		if (s_axi_awvalid && s_axi_awready) begin
			aw_got_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_got_d  = 1'b1;
			wdata_d  = s_axi_wdata;
			wstrb0_d = s_axi_wstrb[0];
		end
		// Perform the write once both halves are held
		if (wr_go) begin
			aw_got_d = 1'b0;
			w_got_d  = 1'b0;
			bvalid_d = 1'b1;
			bresp_d  = `RSS_RESP_OKAY;
			if (awaddr_q == `RSS_OFF_BRK_AUX) begin
				// Only the break disable bit is writable
				if (wstrb0_q) begin
					brk_d = '0;
					brk_d[`RSS_BIT_BRKDIS] = wdata_q[`RSS_BIT_BRKDIS];
				end
			end else if (awaddr_q == `RSS_OFF_OPTION) begin
				if (wstrb0_q) begin
					opt_d = '0;
					opt_d[`RSS_BIT_STOPEN] = wdata_q[`RSS_BIT_STOPEN];
				end
			end else if (awaddr_q == `RSS_OFF_IRQ_EN) begin
				if (wstrb0_q) begin
					ien_d = wdata_q[7:0];
				end
			end else if (awaddr_q == `RSS_OFF_IRQ_CLR) begin
				// Ones clear interrupt status bits
				if (wstrb0_q) begin
					ist_d = ist_q & ~wdata_q[7:0];
				end
			end else if (awaddr_q == `RSS_OFF_CAUSE || awaddr_q == `RSS_OFF_IRQ_STAT) begin
				// Read-only: write ignored
				bresp_d = `RSS_RESP_OKAY;
			end else begin
				bresp_d = `RSS_RESP_SLVERR;
			end
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		// Read: data and side effects on the address handshake
		if (rd_go) begin
			rvalid_d = 1'b1;
			rresp_d  = `RSS_RESP_OKAY;
			rdata_d  = '0;
			if (s_axi_araddr == `RSS_OFF_CAUSE) begin
				rdata_d = {24'h000000, cause_q};
				cause_d = '0;
			end else if (s_axi_araddr == `RSS_OFF_BRK_AUX) begin
				rdata_d = {24'h000000, brk_q};
			end else if (s_axi_araddr == `RSS_OFF_OPTION) begin
				rdata_d = {24'h000000, opt_q};
			end else if (s_axi_araddr == `RSS_OFF_IRQ_STAT) begin
				rdata_d = {24'h000000, ist_q};
			end else if (s_axi_araddr == `RSS_OFF_IRQ_EN) begin
				rdata_d = {24'h000000, ien_q};
			end else if (s_axi_araddr == `RSS_OFF_IRQ_CLR) begin
				// Write-only, reads zero
				rdata_d = '0;
			end else begin
				rresp_d = `RSS_RESP_SLVERR;
			end
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		// New causes win over a clearing read or write
		cause_d = cause_d | ev_set;
		ist_d   = ist_d | ev_set;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cause_q  <= `RSS_CAUSE_RST;
			brk_q    <= `RSS_BRK_AUX_RST;
			opt_q    <= `RSS_OPTION_RST;
			ist_q    <= `RSS_IRQ_RST;
			ien_q    <= `RSS_IRQ_RST;
			aw_got_q <= 1'b0;
			awaddr_q <= 8'h00;
			w_got_q  <= 1'b0;
			wdata_q  <= 32'h00000000;
			wstrb0_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q  <= `RSS_RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= `RSS_RESP_OKAY;
		end else begin
			cause_q  <= cause_d;
			brk_q    <= brk_d;
			opt_q    <= opt_d;
			ist_q    <= ist_d;
			ien_q    <= ien_d;
			aw_got_q <= aw_got_d;
			awaddr_q <= awaddr_d;
			w_got_q  <= w_got_d;
			wdata_q  <= wdata_d;
			wstrb0_q <= wstrb0_d;
			bvalid_q <= bvalid_d;
			bresp_q  <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q  <= rdata_d;
			rresp_q  <= rresp_d;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	always_comb begin
		s_axi_bvalid = bvalid_q;
		s_axi_bresp  = bresp_q;
		s_axi_rvalid = rvalid_q;
		s_axi_rdata  = rdata_q;
		s_axi_rresp  = rresp_q;
		rst_pin_o    = 1'b0;
		rst_pin_oe_n = state_q != RSS_DRIVE;
		chip_reset   = state_q != RSS_IDLE;
		last_cause   = cause_q;
		irq          = |(ist_q & ien_q);
	end

endmodule : rss_top

`default_nettype wire

// [rtl/rss_defs.svh]
// Constants of the reset source and status block: offsets, fields, resets, counts
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define RSS_OFF_CAUSE      8'h00
`define RSS_OFF_BRK_AUX    8'h04
`define RSS_OFF_OPTION     8'h08
`define RSS_OFF_IRQ_STAT   8'h0C
`define RSS_OFF_IRQ_EN     8'h10
`define RSS_OFF_IRQ_CLR    8'h14

// ----------------------------------------------------------------------------
// Cause flag positions (same layout in status, enable and clear registers), then break and option bits
// ----------------------------------------------------------------------------
`define RSS_BIT_POR        7
`define RSS_BIT_PIN        6
`define RSS_BIT_WDOG       5
`define RSS_BIT_BADOP      4
`define RSS_BIT_BADAD      3
`define RSS_BIT_MODE       2
`define RSS_BIT_LOWV       1
`define RSS_BIT_BRKDIS     1
`define RSS_BIT_STOPEN     0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RSS_CAUSE_RST      8'h80
`define RSS_BRK_AUX_RST    8'h00
`define RSS_OPTION_RST     8'h00
`define RSS_IRQ_RST        8'h00

// ----------------------------------------------------------------------------
// Timing counts, in oscillator clock cycles, the system clocks per oscillator cycle, and bus answers
// ----------------------------------------------------------------------------
`define RSS_PIN_CYCLES     32
`define RSS_HOLD_CYCLES    32
`define RSS_LOWV_EXTRA     4096
`define RSS_OSC_DIV        4
`define RSS_RESP_OKAY      2'h0
`define RSS_RESP_SLVERR    2'h2

`endif

// [rtl/rss_pkg.sv]
// Types shared by the reset source and status block
package rss_pkg;
	// Sequencer states, one-hot
	typedef enum logic [3:0] {
		RSS_IDLE  = 4'b0001,
		RSS_DRIVE = 4'b0010,
		RSS_HOLD  = 4'b0100,
		RSS_EXT   = 4'b1000
	} rss_state_e;

	// Eight-bit cause flag vector
	typedef logic [7:0] rss_flags_t;
endpackage : rss_pkg

// [tb/rss_pin_model.sv]
// Reset pin partner: open-drain wire with pull-up and an external pull-down
`timescale 1ns/1ps
`default_nettype none
module rss_pin_model (
	input  wire logic rst_pin_o,    // Device drive value
	input  wire logic rst_pin_oe_n, // Device drive enable, low drives
	input  wire logic ext_low,      // External device pulls pin low
	output logic      pin           // Resolved pin level
);
	// Wired pull-downs over a pull-up, so a released pin reads high
	assign pin = (rst_pin_oe_n || rst_pin_o) && !ext_low;
endmodule : rss_pin_model
`default_nettype wire

// [tb/rss_checker.sv]
// Assertion checker for the reset source and status block
`timescale 1ns/1ps
`default_nettype none
module rss_checker #(
	parameter int unsigned OSC_DIV    = 4,   // System clocks per oscillator cycle
	parameter int unsigned PIN_CYCLES = 32,  // Pin drive time
	parameter int unsigned LOWV_CYCLES = 4128 // Low-voltage pin drive time
) (
	input wire logic                clk,
	input wire logic                rst,
	input wire logic [7:0]          s_axi_araddr,
	input wire logic                s_axi_arvalid,
	input wire logic                s_axi_arready,
	input wire logic                watchdog_overflow,
	input wire logic                illegal_opcode,
	input wire logic                stop_exec,
	input wire logic                unmapped_access,
	input wire logic                opcode_fetch,
	input wire logic                low_voltage_trip,
	input wire logic                monitor_entry,
	input wire logic                monitor_mode,
	input wire logic                break_state,
	input wire logic                rst_pin_hv,
	input wire logic                irq_pin_hv,
	input wire logic                rst_pin_i,
	input wire logic                rst_pin_oe_n,
	input wire logic                chip_reset,
	input wire logic                watchdog_disable,
	input wire rss_pkg::rss_flags_t last_cause
);
	import rss_pkg::*;
	// ----------------------------------------------------------------------
	// Helper counters
	// ----------------------------------------------------------------------
	localparam int unsigned HOLD = 32; // Hold ticks after pin release
	logic [15:0] low_q, low_d; // Cycles with the pin pulled down
	logic [15:0] hld_q, hld_d; // Hold cycles with the pin released
	logic        no_int;       // No internal cause present
	logic        quiet;        // No cause at all
	assign no_int = !(watchdog_overflow || illegal_opcode || stop_exec || (unmapped_access && opcode_fetch)
		|| low_voltage_trip || monitor_entry);
	assign quiet  = no_int && rst_pin_i;
	// Next counts
	always_comb begin
		low_d = rst_pin_oe_n ? 16'h0000 : low_q + 16'h0001;
		hld_d = (chip_reset && rst_pin_oe_n && rst_pin_i) ? hld_q + 16'h0001 : 16'h0000;
	end
	// Count registers, cleared by reset
	always_ff @(posedge clk) begin
		low_q <= rst ? 16'h0000 : low_d;
		hld_q <= rst ? 16'h0000 : hld_d;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wdog_cause_a: assert property (!chip_reset && watchdog_overflow && !watchdog_disable
		|=> last_cause[5] && !rst_pin_oe_n && chip_reset) else $error("watchdog cause not taken");
	badop_cause_a: assert property (!chip_reset && illegal_opcode |=> last_cause[4] && !rst_pin_oe_n)
		else $error("illegal opcode cause not taken");
	badad_cause_a: assert property (!chip_reset && unmapped_access && opcode_fetch
		|=> last_cause[3] && !rst_pin_oe_n) else $error("illegal address cause not taken");
	data_read_a: assert property (!chip_reset && quiet && unmapped_access && !opcode_fetch
		|=> !chip_reset && rst_pin_oe_n) else $error("data read caused a reset");
	lowv_cause_a: assert property (!chip_reset && low_voltage_trip |=> last_cause[1] && !rst_pin_oe_n)
		else $error("low voltage cause not taken");
	mode_cause_a: assert property (!chip_reset && monitor_entry |=> last_cause[2] && !rst_pin_oe_n)
		else $error("monitor entry cause not taken");
	pin_cause_a: assert property (!chip_reset && no_int && !rst_pin_i
		|=> last_cause[6] && chip_reset && rst_pin_oe_n) else $error("pin cause not taken");
	wdog_mon_a: assert property (!break_state
		|-> watchdog_disable == (monitor_mode && (rst_pin_hv || irq_pin_hv))) else $error("disable mismatch");
	wdog_brk_a: assert property (break_state && rst_pin_hv |-> watchdog_disable)
		else $error("break disable missing");
	read_clear_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00 && !chip_reset
		&& quiet |=> last_cause == 8'h00) else $error("status read did not clear");
	por_value_a: assert property ($fell(rst) |-> last_cause == 8'h80 && !chip_reset)
		else $error("power-on flags wrong");
	pin_time_a: assert property ($rose(rst_pin_oe_n) && !$past(rst) |->
		(low_q >= (PIN_CYCLES - 1) * OSC_DIV && low_q <= PIN_CYCLES * OSC_DIV + 1)
		|| (low_q >= (LOWV_CYCLES - 1) * OSC_DIV && low_q <= LOWV_CYCLES * OSC_DIV + 1))
		else $error("pin drive time wrong");
	hold_time_a: assert property ($fell(chip_reset) && !$past(rst) |->
		hld_q >= (HOLD - 1) * OSC_DIV - 2 && hld_q <= HOLD * OSC_DIV + 1) else $error("hold time wrong");
endmodule : rss_checker
bind rss_top rss_checker #(.OSC_DIV(OSC_DIV), .PIN_CYCLES(PIN_CYCLES), .LOWV_CYCLES(LOWV_CYCLES)) u_chk (
	.clk(clk), .rst(rst), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .watchdog_overflow(watchdog_overflow), .illegal_opcode(illegal_opcode),
	.stop_exec(stop_exec), .unmapped_access(unmapped_access), .opcode_fetch(opcode_fetch),
	.low_voltage_trip(low_voltage_trip), .monitor_entry(monitor_entry), .monitor_mode(monitor_mode),
	.break_state(break_state), .rst_pin_hv(rst_pin_hv), .irq_pin_hv(irq_pin_hv), .rst_pin_i(rst_pin_i),
	.rst_pin_oe_n(rst_pin_oe_n), .chip_reset(chip_reset), .watchdog_disable(watchdog_disable),
	.last_cause(last_cause));
`default_nettype wire

// [tb/rss_top_tb.sv]
// Self-checking testbench of the reset source and status block
`timescale 1ns/1ps
`default_nettype none
`include "rss_defs.svh"
module rss_top_tb;
	import rss_pkg::*;
	logic        clk, rst;                          // Clock and power-on reset
	logic [7:0]  awaddr, araddr;                    // Bus addresses
	logic [31:0] wdata, rdata;                      // Bus data
	logic        awvalid, wvalid, bready, arvalid;  // Master handshakes
	logic        rready, awready, wready, bvalid;   // More handshakes
	logic        arready, rvalid;                   // Read handshakes
	logic [1:0]  bresp, rresp;                      // Responses
	logic [7:0]  ev;                                // Causes, bit 7 pulls the pin
	logic        mm, bs, rh, ih;                    // Mode and voltage detects
	logic        pin, pin_o, oe_n, chip_reset;      // Pin and reset state
	logic        wd_dis, irq;                       // Results
	rss_flags_t  cause;                             // Cause flags
	int          bad_count, n_checks;               // Counters
	logic [33:0] exp_q[$];                          // Expected read and write answers
	rss_top #(.LOWV_CYCLES(40)) dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .watchdog_overflow(ev[0]),
		.illegal_opcode(ev[1]), .stop_exec(ev[2]), .unmapped_access(ev[3]), .opcode_fetch(ev[4]),
		.low_voltage_trip(ev[5]), .monitor_entry(ev[6]), .monitor_mode(mm), .break_state(bs),
		.rst_pin_hv(rh), .irq_pin_hv(ih), .rst_pin_i(pin), .rst_pin_o(pin_o), .rst_pin_oe_n(oe_n),
		.chip_reset(chip_reset), .watchdog_disable(wd_dis), .last_cause(cause), .irq(irq));
	rss_pin_model pm (.rst_pin_o(pin_o), .rst_pin_oe_n(oe_n), .ext_low(ev[7]), .pin(pin));
	// Clock at 200 MHz
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Compare and count
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Verdict and end of run
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : summarize
	// Bus read, expectation noted first
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		logic ta, tr;
		int i;
		exp_q.push_back(e);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(negedge clk);
			ta = arvalid && arready;
			tr = rvalid;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
			if (tr) break;
		end
		rready <= 1'b0;
		if (i == 100) begin
			bad_count++;
			summarize();
		end
	endtask : rd
	// Bus write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		int i;
		exp_q.push_back({(a > `RSS_OFF_IRQ_CLR || a[1:0] != 2'h0) ? `RSS_RESP_SLVERR : `RSS_RESP_OKAY, 32'h0});
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) break;
		end
		bready <= 1'b0;
		if (i == 100) begin
			bad_count++;
			summarize();
		end
	endtask : wr
	// Raise causes for three cycles, wait out the sequence, read the flags
	task automatic fire(input logic [7:0] pat, input logic [7:0] exp);
		int i;
		@(posedge clk) ev <= pat;
		repeat (3) @(posedge clk);
		ev <= 8'h00;
		@(negedge clk);
		for (i = 0; i < 2000 && chip_reset !== 1'b0; i++) @(negedge clk);
		if (i == 2000) begin
			bad_count++;
			summarize();
		end
		rd(`RSS_OFF_CAUSE, {2'h0, 24'h000000, exp});
	endtask : fire
	// Read and write answers compared in arrival order
	always @(posedge clk) begin
		if (rvalid && rready) chk({rresp, rdata}, exp_q.size() ? exp_q.pop_front() : 34'h3FFFFFFFF);
		if (bvalid && bready) chk({bresp, 32'h0}, exp_q.size() ? exp_q.pop_front() : 34'h3FFFFFFFF);
	end
	// Hang guard
	initial begin
		repeat (60000) @(posedge clk);
		bad_count++;
		summarize();
	end
	// Main sequence
	initial begin
		int   i, k;
		logic e;
		{rst, ev, mm, bs, rh, ih, awaddr, araddr, wdata} = {1'b1, 60'h0};
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		void'($urandom(32'h5DE2D528));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(`RSS_OFF_CAUSE, 34'h80);
		rd(`RSS_OFF_CAUSE, 34'h00);
		rd(`RSS_OFF_BRK_AUX, 34'h00);
		rd(8'h40, {`RSS_RESP_SLVERR, 32'h0});
		wr(8'h40, 32'h0);
		$display("Test reset done");
		fire(8'h01, 8'h20);
		chk(34'(irq), 34'h0);
		fire(8'h02, 8'h10);
		fire(8'h04, 8'h10);
		fire(8'h18, 8'h08);
		fire(8'h08, 8'h00);
		fire(8'h20, 8'h02);
		fire(8'h40, 8'h04);
		fire(8'h80, 8'h40);
		fire(8'h21, 8'h22);
		wr(`RSS_OFF_OPTION, 32'h1);
		fire(8'h04, 8'h00);
		wr(`RSS_OFF_OPTION, 32'h0);
		$display("Test causes done");
		wr(`RSS_OFF_IRQ_EN, 32'h20);
		@(negedge clk);
		chk(34'(irq), 34'h1);
		wr(`RSS_OFF_IRQ_CLR, 32'h20);
		@(negedge clk);
		chk(34'(irq), 34'h0);
		rd(`RSS_OFF_IRQ_STAT, 34'h5E);
		$display("Test interrupt done");
		for (k = 0; k < 2; k++) begin
			wr(`RSS_OFF_BRK_AUX, 32'(k * 2));
			rd(`RSS_OFF_BRK_AUX, 34'(k * 2));
			for (i = 0; i < 12; i++) begin
				@(posedge clk) {mm, bs, rh, ih} <= 4'($urandom);
				@(negedge clk);
				e = (mm & (rh | ih)) | (bs & rh) | (bs & (k == 1));
				chk(34'(wd_dis), 34'(e));
			end
		end
		@(posedge clk) {mm, bs, rh, ih} <= 4'b0100;
		fire(8'h01, 8'h00);
		$display("Test watchdog disable done");
		summarize();
	end
endmodule : rss_top_tb
`default_nettype wire
